/* shared/sac_pkg.sv */
// Shared constants for the sense amplifier calibration control block.
package sac_pkg;
    // Register byte addresses.
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_CAL    = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_FAULT  = 8'h0C;
    localparam logic [7:0] REG_MASK   = 8'h10;
    localparam logic [7:0] REG_TRIM0  = 8'h14;
    // Control register fields.
    localparam int CTRL_GAIN_LSB = 0;
    localparam int CTRL_UNIDIR   = 2;
    localparam int CTRL_AUTO_EN  = 3;
    localparam int CTRL_FET      = 4;
    localparam int CTRL_LSREF    = 5;
    localparam int CTRL_W        = 6;
    // Status register fields.
    localparam int STAT_BUSY_LSB  = 0;
    localparam int STAT_READY_LSB = 3;
    localparam int STAT_GLOBAL    = 6;
    // Sizes.
    localparam int NUM_AMP = 3;
    localparam int FLT_W   = 8;
    localparam int TRIM_W  = 5;
    // Gain codes: 5, 10, 20 and 40 V/V.
    localparam logic [1:0] GAIN_5  = 2'h0;
    localparam logic [1:0] GAIN_40 = 2'h3;
    // Faults that the mask pin may switch off on the pin variant.
    localparam logic [FLT_W-1:0] FLT_MASKABLE = 8'hFC;
    // Trim routine length: 50 us at a 50 ns clock, rounded down.
    localparam int CLK_PERIOD_NS   = 50;
    localparam int AUTOCAL_TIME_NS = 50000;
    localparam int AUTOCAL_CYC     = AUTOCAL_TIME_NS / CLK_PERIOD_NS;
    localparam int STEP_CYC        = AUTOCAL_CYC / TRIM_W;
    // Trim engine states.
    typedef enum logic [0:0] {
        SAC_IDLE = 1'b0,
        SAC_TRIM = 1'b1
    } sac_state_t;
endpackage

/* shared/sac_chan_if.sv */
// Link between the control core and one amplifier trim engine.
`timescale 1ns/10ps
`default_nettype none
interface sac_chan_if;
    import sac_pkg::*;
    logic              start;  // One-cycle request to run the trim routine.
    logic              busy;   // High while the routine runs.
    logic              done;   // One-cycle pulse when the trim code is stored.
    logic [TRIM_W-1:0] trim;   // Stored trim code.
    modport ctrl (output start, input busy, done, trim);
    modport chan (input start, output busy, done, trim);
endinterface
`default_nettype wire

/* rtl/sac_amp_chan.sv */
// Per-amplifier automatic offset trim engine (successive approximation).
`timescale 1ns/10ps
`default_nettype none
module sac_amp_chan
    import sac_pkg::*;
(
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // Comparator: amplifier output sits above its midpoint.
    input  wire logic offset_high_i,
    // Control link.
    sac_chan_if.chan  ch
);
    // ************************************************************
    // Trim state.
    // ************************************************************
    sac_state_t        state_reg;  // Engine state.
    logic [15:0]       step_reg;   // Cycles left in this bit step.
    logic [TRIM_W-1:0] trim_reg;   // Trim code under test, then stored.
    logic [TRIM_W-1:0] bit_reg;    // One-hot bit under test.
    logic              done_reg;   // Completion pulse.

    wire step_end = (step_reg == 16'h0001);

    // Each bit gets an equal share of the routine; code is kept when it ends.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_reg <= SAC_IDLE;
            step_reg  <= 16'h0000;
            trim_reg  <= {1'b1, {(TRIM_W-1){1'b0}}};
            bit_reg   <= {1'b1, {(TRIM_W-1){1'b0}}};
            done_reg  <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            case (state_reg)
                SAC_IDLE: begin
                    // A new start restarts the search from mid-scale.
                    if (ch.start) begin
                        state_reg <= SAC_TRIM;
                        step_reg  <= 16'(STEP_CYC);
                        trim_reg  <= {1'b1, {(TRIM_W-1){1'b0}}};
                        bit_reg   <= {1'b1, {(TRIM_W-1){1'b0}}};
                    end
                end
                SAC_TRIM: begin
                    if (!step_end) begin
                        step_reg <= step_reg - 16'h0001;
                    end else begin
                        // Drop the bit under test if the output still reads high.
                        trim_reg <= (offset_high_i ? (trim_reg & ~bit_reg) : trim_reg)
                                    | (bit_reg >> 1);
                        bit_reg  <= bit_reg >> 1;
                        step_reg <= 16'(STEP_CYC);
                        if (bit_reg[0]) begin
                            state_reg <= SAC_IDLE;  // Trim stored, amplifier released.
                            done_reg  <= 1'b1;
                        end
                    end
                end
                default: state_reg <= SAC_IDLE;
            endcase
        end
    end

    assign ch.busy = (state_reg == SAC_TRIM);
    assign ch.done = done_reg;
    assign ch.trim = trim_reg;

    // The routine finishes inside its 50 us budget.
    AST_TRIM_BOUND: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(ch.busy) |-> ##[1:1000] ch.done)
        else $error("Trim routine overran its time budget.");
endmodule // sac_amp_chan
`default_nettype wire

/* rtl/sac_ctrl.sv */
// Current sense amplifier gain, calibration and fault summary control.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Gain selects 5, 10, 20 or 40.
// - Divider removal bit selects unidirectional operation.
// - Own request bit calibrates only that amplifier.
// - Calibration requests accepted at any time.
// - Calibration pin shorts all three amplifiers.
// - Power-up trim starts on reference good.
// - Trim, store codes, then release amplifiers.
// - Trim runs bidirectional, then restores unidirectional.
// - Auto enabled: request bit reruns trim.
// - Trim forces maximum gain, then restores.
// - Drop sensing routes input to drain.
// - Drop sensing forces monitor reference negative.
// - Drop sensing enables amplifier after drive phase.
// - Low-side off in drop mode shorts inputs.
// - Fault sets own bit and summary.
// - Pin variant reports faults on line only.
// - Protections disableable by register or pin.
// - Open-drain error line low on fault.
module sac_ctrl
    import sac_pkg::*;
#(
    parameter int NA = NUM_AMP  // Number of amplifiers.
) (
    // Clock and reset.
    input  wire logic          clk_i,
    input  wire logic          resetn_i,
    // Register port.
    input  wire logic [7:0]    addr_i,
    input  wire logic [31:0]   wdata_i,
    input  wire logic          wr_i,
    input  wire logic          rd_i,
    output logic [31:0]        rdata_o,
    // Device pins and analog status.
    input  wire logic          pin_variant_i,
    input  wire logic          cal_pin_i,
    input  wire logic          protection_mask_pin_n_i,
    input  wire logic          vref_ok_i,
    input  wire logic [NA-1:0] offset_high_i,
    input  wire logic [NA-1:0] lowside_on_i,
    input  wire logic [NA-1:0] drive_phase_done_i,
    input  wire logic [FLT_W-1:0] fault_event_i,
    // Amplifier controls.
    output logic [1:0]         amp_gain_setting_o,
    output logic               unidirectional_o,
    output logic [NA-1:0]      amp_input_short_o,
    output logic [NA-1:0]      shunt_disconnect_o,
    output logic [NA-1:0]      amp_enable_o,
    output logic [NA*TRIM_W-1:0] amp_trim_o,
    output logic               fet_drop_sense_select_o,
    output logic               lowside_monitor_ref_sn_o,
    // Open-drain error line.
    output logic               error_line_low_o,
    output logic               error_line_low_oe_o
);
    // ************************************************************
    // Register storage.
    // ************************************************************
    logic [CTRL_W-1:0] ctrl_reg;      // Gain, mode and sensing controls.
    logic [NA-1:0]     cal_req_reg;   // amp_cal_request bits.
    logic [FLT_W-1:0]  fault_reg;     // Sticky fault bits.
    logic [FLT_W-1:0]  mask_reg;      // Per-fault disable bits.
    logic              pwr_pend_reg;  // Power-up trim still owed.
    logic [NA-1:0]     ready_reg;     // Amplifier trimmed and released.
    logic [NA-1:0]     fet_en_reg;    // Drop-sense enable after drive phase.
    logic [31:0]       rdata_reg;     // Read data, one cycle after the strobe.

    // Output registers.
    logic [1:0]    gain_reg;
    logic          unidir_reg;
    logic [NA-1:0] short_reg;
    logic [NA-1:0] disc_reg;
    logic [NA-1:0] en_reg;
    logic          fet_reg;
    logic          lsref_reg;
    logic          err_reg;

    // ************************************************************
    // Trim engines.
    // ************************************************************
    logic [NA-1:0] busy_w;   // Per-amplifier routine in progress.
    logic [NA-1:0] done_w;   // Per-amplifier completion pulse.
    logic [NA-1:0] start_w;  // Per-amplifier start request.

    // One engine per amplifier keeps their states apart.
    for (genvar g = 0; g < NA; g++) begin : g_amp
        sac_chan_if ch ();
        sac_amp_chan u_chan (
            .clk_i         (clk_i),
            .resetn_i      (resetn_i),
            .offset_high_i (offset_high_i[g]),
            .ch            (ch.chan)
        );
        assign ch.start  = start_w[g];
        assign busy_w[g] = ch.busy;
        assign done_w[g] = ch.done;
        assign amp_trim_o[g*TRIM_W +: TRIM_W] = ch.trim;
    end

    // ************************************************************
    // Decode.
    // ************************************************************
    // Address match for one register; the write strobes add wr_i.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    wire wr_ctrl  = wr_i && hit(addr_i, REG_CTRL);
    wire wr_cal   = wr_i && hit(addr_i, REG_CAL);
    wire wr_fault = wr_i && hit(addr_i, REG_FAULT);
    wire wr_mask  = wr_i && hit(addr_i, REG_MASK);

    wire [1:0] prog_gain = ctrl_reg[CTRL_GAIN_LSB +: 2];
    wire       auto_en   = ctrl_reg[CTRL_AUTO_EN];
    wire       fet_mode  = ctrl_reg[CTRL_FET] && !pin_variant_i;
    wire       any_busy  = |busy_w;

    // Power-up trim on all amplifiers once the reference is good.
    wire pwr_start = pwr_pend_reg && vref_ok_i;

    // With auto mode on, a newly set request bit reruns the trim.
    wire [NA-1:0] rt_start = (wr_cal && auto_en && !pin_variant_i)
                             ? (wdata_i[NA-1:0] & ~cal_req_reg) : '0;
    assign start_w = ({NA{pwr_start}} | rt_start) & ~busy_w;

    // Manual calibration only where auto mode is off.
    wire [NA-1:0] man_cal = (auto_en || pin_variant_i) ? '0 : cal_req_reg;

    // Drop-sense off phase shorts the inputs.
    wire [NA-1:0] fet_off = fet_mode ? ~lowside_on_i : '0;

    // The pin shorts every amplifier, on either variant.
    wire [NA-1:0] short_next = {NA{cal_pin_i}} | man_cal | busy_w | fet_off;
    wire [NA-1:0] disc_next  = {NA{cal_pin_i}} | man_cal | busy_w;

    // Disabled faults: register on the serial variant, pin otherwise.
    wire [FLT_W-1:0] flt_dis = pin_variant_i
                               ? (protection_mask_pin_n_i ? '0 : FLT_MASKABLE)
                               : mask_reg;
    wire [FLT_W-1:0] flt_live = fault_event_i & ~flt_dis;
    wire [FLT_W-1:0] flt_clr  = wr_fault ? wdata_i[FLT_W-1:0] : '0;

    // Summary is the OR of every individual bit.
    wire global_flt = |fault_reg;

    // Pin variant reports on the line only, from live faults.
    wire err_next = pin_variant_i ? |flt_live : (global_flt || |flt_live);

    // ************************************************************
    // Register writes and sticky state.
    // ************************************************************
    // Requests are taken regardless of bridge activity.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ctrl_reg    <= '0;
            cal_req_reg <= '0;
            mask_reg    <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= wdata_i[CTRL_W-1:0];
            end
            if (wr_cal) begin
                cal_req_reg <= wdata_i[NA-1:0];
            end
            if (wr_mask) begin
                mask_reg <= wdata_i[FLT_W-1:0];
            end
        end
    end

    // A fault in the clearing cycle survives: set wins over clear.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            fault_reg <= '0;
        end else if (pin_variant_i) begin
            fault_reg <= '0;
        end else begin
            fault_reg <= (fault_reg & ~flt_clr) | flt_live;
        end
    end

    // Trim completion releases each amplifier on its own.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pwr_pend_reg <= 1'b1;
            ready_reg    <= '0;
        end else begin
            if (pwr_start) begin
                pwr_pend_reg <= 1'b0;
            end
            ready_reg <= (ready_reg | done_w) & ~start_w;
        end
    end

    // Drop sense enables after the drive phase, drops at turn-off.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            fet_en_reg <= '0;
        end else begin
            fet_en_reg <= lowside_on_i & (fet_en_reg | drive_phase_done_i);
        end
    end

    // ************************************************************
    // Registered outputs.
    // ************************************************************
    // Trim forces maximum gain and bidirectional mode on every amplifier.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            gain_reg   <= GAIN_5;
            unidir_reg <= 1'b0;
            short_reg  <= '0;
            disc_reg   <= '0;
            en_reg     <= '0;
            fet_reg    <= 1'b0;
            lsref_reg  <= 1'b0;
            err_reg    <= 1'b0;
        end else begin
            gain_reg   <= any_busy ? GAIN_40 : prog_gain;
            unidir_reg <= ctrl_reg[CTRL_UNIDIR] && !any_busy
                          && !pin_variant_i;
            short_reg  <= short_next;
            disc_reg   <= disc_next;
            en_reg     <= ready_reg & ~busy_w & (fet_mode ? fet_en_reg : {NA{1'b1}});
            fet_reg    <= fet_mode;
            lsref_reg  <= fet_mode || ctrl_reg[CTRL_LSREF];
            err_reg    <= err_next;
        end
    end

    assign amp_gain_setting_o       = gain_reg;
    assign unidirectional_o         = unidir_reg;
    assign amp_input_short_o        = short_reg;
    assign shunt_disconnect_o       = disc_reg;
    assign amp_enable_o             = en_reg;
    assign fet_drop_sense_select_o  = fet_reg;
    assign lowside_monitor_ref_sn_o = lsref_reg;
    // Open drain: output held low, enable drives it while a fault stands.
    assign error_line_low_o         = 1'b0;
    assign error_line_low_oe_o      = err_reg;

    // ************************************************************
    // Read port.
    // ************************************************************
    logic [31:0] rdata_next;  // Read data before the output register.

    // Unmapped addresses and unused bits read as zero.
    always_comb begin
        logic [31:0] v;
        v = 32'h0000_0000;
        case (addr_i)
            REG_CTRL:   v[CTRL_W-1:0] = ctrl_reg;
            REG_CAL:    v[NA-1:0]     = cal_req_reg;
            REG_STATUS: begin
                v[STAT_BUSY_LSB  +: NA] = busy_w;
                v[STAT_READY_LSB +: NA] = ready_reg;
                v[STAT_GLOBAL]          = global_flt;
            end
            REG_FAULT:  v[FLT_W-1:0] = fault_reg;
            REG_MASK:   v[FLT_W-1:0] = mask_reg;
            default: begin
                for (int i = 0; i < NA; i++) begin
                    if (addr_i == REG_TRIM0 + 8'(4 * i)) begin
                        v[TRIM_W-1:0] = amp_trim_o[i*TRIM_W +: TRIM_W];
                    end
                end
            end
        endcase
        rdata_next = v;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rd_i ? rdata_next : 32'h0000_0000;
        end
    end
    assign rdata_o = rdata_reg;

    // ************************************************************
    // Checks.
    // ************************************************************
    AST_GAIN_MAX: assert property (@(posedge clk_i) disable iff (!resetn_i)
        any_busy |=> amp_gain_setting_o == GAIN_40)
        else $error("Gain not forced to maximum during trim.");
    AST_GAIN_PROG: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (!any_busy && wr_ctrl) ##1 !any_busy |=>
        amp_gain_setting_o == $past(wdata_i[1:0], 2))
        else $error("Programmed gain not applied.");
    AST_BIDIR_TRIM: assert property (@(posedge clk_i) disable iff (!resetn_i)
        any_busy |=> !unidirectional_o)
        else $error("Unidirectional mode held during trim.");
    AST_UNIDIR: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (!any_busy && !pin_variant_i && ctrl_reg[CTRL_UNIDIR]) |=> unidirectional_o)
        else $error("Divider removal did not select unidirectional mode.");
    AST_PIN_CAL: assert property (@(posedge clk_i) disable iff (!resetn_i)
        cal_pin_i |=> (&amp_input_short_o) && (&shunt_disconnect_o))
        else $error("Calibration pin did not short every amplifier.");
    AST_LSREF: assert property (@(posedge clk_i) disable iff (!resetn_i)
        fet_mode |=> lowside_monitor_ref_sn_o && fet_drop_sense_select_o)
        else $error("Drop sensing did not force the monitor reference.");
    AST_FET_EN: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (fet_mode && !fet_en_reg[0]) |=> !amp_enable_o[0])
        else $error("Amplifier enabled before the drive phase ended.");
    AST_ERR_LINE: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (|flt_live) |=> error_line_low_oe_o [*1] ##0 (pin_variant_i || global_flt))
        else $error("Error line or summary bit missed a live fault.");
    AST_PWR_TRIM: assert property (@(posedge clk_i) disable iff (!resetn_i)
        pwr_start |=> &busy_w)
        else $error("Power-up trim did not start on reference good.");
endmodule // sac_ctrl
`default_nettype wire

/* verif/sac_amp_model.sv */
// Behavioural model of the three amplifier offset comparators.
`timescale 1ns/10ps
`default_nettype none
module sac_amp_model
    import sac_pkg::*;
(
    // Trim codes from the block.
    input  wire logic [NUM_AMP*TRIM_W-1:0] amp_trim_i,
    // Comparator results back to the block.
    output logic [NUM_AMP-1:0]             offset_high_o
);
    // Each amplifier has its own offset, so a shared trim code would be caught.
    localparam logic [3*TRIM_W-1:0] ZERO_AT = 15'h2C6A;
    // The output stays above midpoint while the trim overshoots the offset.
    always_comb begin
        for (int i = 0; i < NUM_AMP; i++) begin
            offset_high_o[i] = amp_trim_i[i*TRIM_W+:TRIM_W] > ZERO_AT[i*TRIM_W+:TRIM_W];
        end
    end
endmodule // sac_amp_model
`default_nettype wire

/* verif/sac_ctrl_tb.sv */
// Self-checking bench for the sense amplifier calibration control block.
`timescale 1ns/10ps
`default_nettype none
module sac_ctrl_tb;
    import sac_pkg::*;
    // One ordinary case: control word and the settings it should give.
    typedef struct packed {
        logic [5:0] ctrl;
        logic [1:0] gain;
        logic       uni;
        logic       fet;
    } sac_row_t;
    logic         clk_i = 1'b0;
    logic         resetn_i = 1'b0;
    logic [7:0]   addr_i = 8'h00;
    logic [31:0]  wdata_i = 32'h0;
    logic         wr_i = 1'b0;
    logic         rd_i = 1'b0;
    logic         pin_variant_i = 1'b0;
    logic         cal_pin_i = 1'b0;
    logic         protection_mask_pin_n_i = 1'b1;
    logic         vref_ok_i = 1'b0;
    logic [2:0]   offset_high_i;
    logic [2:0]   lowside_on_i = 3'h0;
    logic [2:0]   drive_phase_done_i = 3'h0;
    logic [7:0]   fault_event_i = 8'h00;
    logic [31:0]  rdata_o;
    logic [1:0]   gain_o;
    logic         uni_o;
    logic [2:0]   short_o;
    logic [2:0]   disc_o;
    logic [2:0]   en_o;
    logic [14:0]  trim_o;
    logic         fet_o;
    logic         sn_o;
    logic         line_o;
    logic         oe_o;
    int           bad_count = 0;
    int           cmp_count = 0;
    int           cyc = 0;
    sac_row_t     rows [6] = '{'{6'h00, 2'h0, 1'b0, 1'b0}, '{6'h05, 2'h1, 1'b1, 1'b0},
                               '{6'h02, 2'h2, 1'b0, 1'b0}, '{6'h07, 2'h3, 1'b1, 1'b0},
                               '{6'h10, 2'h0, 1'b0, 1'b1}, '{6'h33, 2'h3, 1'b0, 1'b1}};
    sac_ctrl i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_variant_i(pin_variant_i),
        .cal_pin_i(cal_pin_i), .protection_mask_pin_n_i(protection_mask_pin_n_i),
        .vref_ok_i(vref_ok_i), .offset_high_i(offset_high_i), .lowside_on_i(lowside_on_i),
        .drive_phase_done_i(drive_phase_done_i), .fault_event_i(fault_event_i),
        .amp_gain_setting_o(gain_o), .unidirectional_o(uni_o), .amp_input_short_o(short_o),
        .shunt_disconnect_o(disc_o), .amp_enable_o(en_o), .amp_trim_o(trim_o),
        .fet_drop_sense_select_o(fet_o), .lowside_monitor_ref_sn_o(sn_o),
        .error_line_low_o(line_o), .error_line_low_oe_o(oe_o));
    sac_amp_model i_amp (.amp_trim_i(trim_o), .offset_high_o(offset_high_i));
    // 20 MHz clock.
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    // A hang is cut short well past the longest expected run.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            bad_count++;
            end_sim();
        end
    end
    // Compare one value and count it.
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // Wait some edges, then step past the edge so outputs have settled.
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // One-cycle register write.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // One-cycle register read, data taken in the following cycle only.
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk("rdata", rdata_o, e);
    endtask
    // Print the counts and the verdict, then stop.
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        settle(2);
        chk("gain_rst", 32'(gain_o), 32'h0);
        chk("oe_rst", 32'(oe_o), 32'h0);
        // Power-up trim: all busy at maximum gain with inputs shorted.
        @(posedge clk_i);
        vref_ok_i <= 1'b1;
        settle(3);
        chk("gain_trim", 32'(gain_o), 32'(GAIN_40));
        chk("short_trim", 32'(short_o), 32'h7);
        rdc(REG_STATUS, 32'h07);
        settle(1005);
        rdc(REG_STATUS, 32'h38);
        chk("gain_back", 32'(gain_o), 32'(GAIN_5));
        // Each stored code lands on its own amplifier's zero point in the model.
        rdc(REG_TRIM0, 32'h0A);
        rdc(REG_TRIM0 + 8'h04, 32'h03);
        rdc(REG_TRIM0 + 8'h08, 32'h0B);
        // Ordinary settings from the table; the last row leaves drop sensing on.
        foreach (rows[k]) begin
            wr(REG_CTRL, 32'(rows[k].ctrl));
            settle(2);
            chk("gain", 32'(gain_o), 32'(rows[k].gain));
            chk("unidir", 32'(uni_o), 32'(rows[k].uni));
            chk("fet", 32'(fet_o), 32'(rows[k].fet));
            if (rows[k].fet) begin
                chk("ref_sn", 32'(sn_o), 32'h1);
            end
        end
        // Drop sensing: output valid only after the drive phase, shorted when off.
        @(posedge clk_i);
        lowside_on_i <= 3'h1;
        settle(2);
        chk("en_early", 32'(en_o), 32'h0);
        @(posedge clk_i);
        drive_phase_done_i <= 3'h1;
        @(posedge clk_i);
        drive_phase_done_i <= 3'h0;
        settle(2);
        chk("en_done", 32'(en_o), 32'h1);
        chk("short_off", 32'(short_o), 32'h6);
        @(posedge clk_i);
        lowside_on_i <= 3'h5;
        // Manual request for amplifier 1 alone while the bridge switches.
        wr(REG_CTRL, 32'h0);
        wr(REG_CAL, 32'h2);
        settle(2);
        chk("short_man", 32'(short_o), 32'h2);
        chk("disc_man", 32'(disc_o), 32'h2);
        wr(REG_CAL, 32'h0);
        // Run-time trim of amplifier 0 from unidirectional gain 10.
        wr(REG_CTRL, 32'h0D);
        wr(REG_CAL, 32'h1);
        settle(2);
        chk("gain_auto", 32'(gain_o), 32'(GAIN_40));
        chk("uni_auto", 32'(uni_o), 32'h0);
        chk("short_auto", 32'(short_o), 32'h1);
        // Amplifier 0 is withdrawn while it trims; the others stay released.
        rdc(REG_STATUS, 32'h31);
        settle(1010);
        chk("gain_rest", 32'(gain_o), 32'h1);
        chk("uni_rest", 32'(uni_o), 32'h1);
        rdc(REG_STATUS, 32'h38);
        rdc(REG_TRIM0, 32'h0A);
        wr(REG_CAL, 32'h0);
        wr(REG_CTRL, 32'h0);
        // Faults on the serial variant: sticky bit, summary, clear and mask.
        @(posedge clk_i);
        fault_event_i <= 8'h04;
        @(posedge clk_i);
        fault_event_i <= 8'h00;
        settle(2);
        rdc(REG_FAULT, 32'h04);
        rdc(REG_STATUS, 32'h78);
        chk("oe_flt", 32'(oe_o), 32'h1);
        chk("line", 32'(line_o), 32'h0);
        wr(REG_FAULT, 32'h04);
        settle(2);
        rdc(REG_FAULT, 32'h00);
        chk("oe_clr", 32'(oe_o), 32'h0);
        // A fault in the very cycle of its clear must keep its bit.
        @(posedge clk_i);
        fault_event_i <= 8'h04;
        addr_i <= REG_FAULT;
        wdata_i <= 32'h04;
        wr_i <= 1'b1;
        @(posedge clk_i);
        fault_event_i <= 8'h00;
        wr_i <= 1'b0;
        rdc(REG_FAULT, 32'h04);
        wr(REG_FAULT, 32'h04);
        wr(REG_MASK, 32'h04);
        @(posedge clk_i);
        fault_event_i <= 8'h04;
        @(posedge clk_i);
        fault_event_i <= 8'h00;
        settle(2);
        rdc(REG_FAULT, 32'h00);
        rdc(8'hFC, 32'h0);
        // Pin variant: line only, mask pin drops maskable faults.
        @(posedge clk_i);
        pin_variant_i <= 1'b1;
        fault_event_i <= 8'h08;
        settle(3);
        chk("oe_pin", 32'(oe_o), 32'h1);
        rdc(REG_FAULT, 32'h00);
        @(posedge clk_i);
        protection_mask_pin_n_i <= 1'b0;
        settle(3);
        chk("oe_masked", 32'(oe_o), 32'h0);
        @(posedge clk_i);
        fault_event_i <= 8'h01;
        cal_pin_i <= 1'b1;
        settle(3);
        chk("oe_unmask", 32'(oe_o), 32'h1);
        chk("short_pin", 32'(short_o), 32'h7);
        chk("disc_pin", 32'(disc_o), 32'h7);
        end_sim();
    end
endmodule // sac_ctrl_tb
`default_nettype wire
